// ### aio_pkg.sv
// Shared constants and types for the analog I/O value path
package aio_pkg;
	localparam int N_IN = 4;
	localparam int N_OUT = 2;
	localparam int REC_BYTES = 14;
	localparam int IDX_W = 4;
	localparam int RAW_W = 32;
	localparam int WORD_W = 16;
	localparam int DAC_W = 12;
	localparam int CNT_W = 22;
	localparam int WIDE_W = 48;
	localparam int SIGN_BIT = 15;
	localparam int DAC_MSB = 14;
	localparam int DAC_LSB = 3;

	localparam int CLK_MHZ = 125;
	localparam int T_INT16_US = 16600;
	localparam int T_INT20_US = 20000;
	localparam int T_OUT_US = 500;

	localparam logic signed [15:0] W_OVERFLOW = 16'sh7fff;
	localparam logic signed [15:0] W_UNDERFLOW = 16'sh8000;
	localparam logic signed [15:0] W_PRM_ERROR = 16'sh7fff;
	localparam logic signed [15:0] LIN_OVER_MAX = 16'sh7eff;
	localparam logic signed [15:0] LIN_UNDER_MIN = 16'shed00;
	localparam logic signed [15:0] TC_OVER_MAX = 16'sh3c8c;
	localparam logic signed [15:0] TC_UNDER_MIN = 16'shc75c;
	localparam logic signed [15:0] TF_OVER_MAX = 16'sh797c;
	localparam logic signed [15:0] TF_UNDER_MIN = 16'sha68c;
	localparam logic signed [15:0] OUT_MAX = 16'sh7eff;
	localparam logic [11:0] DAC_ZERO = 12'h000;

	localparam logic signed [47:0] FS_COUNTS = 48'sh6c00;
	localparam logic signed [47:0] FS_RAW = 48'sh2710;
	localparam logic signed [47:0] F_MUL = 48'sh9;
	localparam logic signed [47:0] F_DIV = 48'sh5;
	localparam logic signed [47:0] F_OFS = 48'shc80;

	localparam int BYTE_BASE = 0;
	localparam int BYTE_INTEG = 1;
	localparam int BYTE_IN0 = 2;
	localparam int BYTE_OUT0 = 6;
	localparam int VOLT_CH_MIN = 2;

	localparam logic [3:0] TYPE_OFF = 4'h0;
	localparam logic [3:0] TYPE_VOLT = 4'h1;
	localparam logic [3:0] TYPE_RES = 4'h4;
	localparam logic [3:0] TYPE_RTD = 4'h8;
	localparam logic [3:0] RNG_OFF = 4'h0;
	localparam logic [3:0] RNG_10V = 4'h8;
	localparam logic [3:0] RNG_10K = 4'h9;
	localparam logic [3:0] RNG_PT = 4'h0;
	localparam logic [1:0] INTEG_16MS = 2'h1;
	localparam logic [1:0] INTEG_20MS = 2'h2;

	localparam logic [7:0] DEF_BASE = 8'h00;
	localparam logic [7:0] DEF_INTEG = 8'haa;
	localparam logic [7:0] DEF_IN_CFG = 8'h80;
	localparam logic [7:0] DEF_OUT_CFG = 8'h18;
	localparam logic [7:0] DEF_SPARE = 8'h00;

	typedef enum logic [3:0] {
		MODE_OFF = 4'b0001,
		MODE_VOLT = 4'b0010,
		MODE_RES = 4'b0100,
		MODE_RTD = 4'b1000
	} in_mode_t;
endpackage

// ### aio_link.sv
// Backplane link between the controller and the analog I/O device
`timescale 1ns/1ns
interface aio_link;
	import aio_pkg::*;
	logic run;
	logic prm_valid;
	logic prm_first;
	logic [7:0] prm_byte;
	logic [N_IN-1:0][WORD_W-1:0] in_word;
	logic [N_OUT-1:0][WORD_W-1:0] out_word;
	modport dev (input run, input prm_valid, input prm_first, input prm_byte, input out_word, output in_word);
	modport ctl (output run, output prm_valid, output prm_first, output prm_byte, output out_word, input in_word);
endinterface

// ### in_scaler.sv
// Scaling and range limiting of one input measurement
`timescale 1ns/1ns
module in_scaler (
	input wire aio_pkg::in_mode_t mode_i,
	input wire logic fahrenheit_i,
	input wire logic signed [aio_pkg::RAW_W-1:0] raw_i,
	output logic signed [aio_pkg::WORD_W-1:0] word_o
);
	import aio_pkg::*;
	logic signed [WIDE_W-1:0] wide;
	logic signed [WIDE_W-1:0] val;
	logic signed [WIDE_W-1:0] hi;
	logic signed [WIDE_W-1:0] lo;

	always_comb begin
		wide = WIDE_W'(raw_i);
		val = wide;
		hi = WIDE_W'(LIN_OVER_MAX);
		lo = WIDE_W'(LIN_UNDER_MIN);
		case (mode_i)
			MODE_VOLT, MODE_RES: begin
				// Millivolts or ohms to counts, full scale 27648
				val = (wide * FS_COUNTS) / FS_RAW;
			end
			MODE_RTD: begin
				// Hundredths of a degree pass straight through in Celsius, scaled by 9/5 plus 3200 in Fahrenheit
				if (fahrenheit_i) begin
					val = (wide * F_MUL) / F_DIV + F_OFS;
					hi = WIDE_W'(TF_OVER_MAX);
					lo = WIDE_W'(TF_UNDER_MIN);
				end else begin
					val = wide;
					hi = WIDE_W'(TC_OVER_MAX);
					lo = WIDE_W'(TC_UNDER_MIN);
				end
			end
			default: begin
				val = WIDE_W'(W_PRM_ERROR);
			end
		endcase
		if (mode_i == MODE_OFF) begin
			word_o = W_PRM_ERROR;
		end else if (val > hi) begin
			word_o = W_OVERFLOW;
		end else if (val < lo) begin
			word_o = W_UNDERFLOW;
		end else begin
			word_o = val[WORD_W-1:0];
		end
	end
endmodule

// ### aio_device.sv
// Analog I/O device end: parameter intake, conversion scan, value coding
`timescale 1ns/1ns
module aio_device #(
	parameter int INT16_CYC = aio_pkg::T_INT16_US * aio_pkg::CLK_MHZ,
	parameter int INT20_CYC = aio_pkg::T_INT20_US * aio_pkg::CLK_MHZ,
	parameter int OUT_CYC = aio_pkg::T_OUT_US * aio_pkg::CLK_MHZ
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	aio_link.dev link,
	input wire logic fahrenheit_i,
	input wire logic [aio_pkg::N_IN-1:0][aio_pkg::RAW_W-1:0] raw_i,
	output logic [aio_pkg::N_OUT-1:0][aio_pkg::DAC_W-1:0] dac_o,
	output logic [7:0] data_base_o,
	output logic [aio_pkg::N_IN-1:0] prm_error_o,
	output logic [aio_pkg::N_IN+aio_pkg::N_OUT-1:0] slot_done_o
);
	import aio_pkg::*;
	localparam int N_SLOT = N_IN + N_OUT;

	typedef enum logic [1:0] {
		SC_PICK = 2'b01,
		SC_CONV = 2'b10
	} scan_state_t;

	logic [REC_BYTES-1:0][7:0] shadow;
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] next_idx;
	logic run_q;
	logic apply;
	logic rec_bad;
	logic [7:0] act_base;
	logic [7:0] act_integ;
	logic [N_IN-1:0][7:0] act_in;
	logic [N_OUT-1:0][7:0] act_out;
	logic [N_IN-1:0] in_err;
	logic [N_IN-1:0] in_live;
	logic [N_OUT-1:0] out_live;
	logic [N_SLOT-1:0] slot_live;
	logic [N_IN-1:0][WORD_W-1:0] in_word_q;
	scan_state_t state;
	logic [2:0] slot;
	logic [2:0] next_slot;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] slot_len;
	logic slot_end;

	// Next live slot after cur, wrapping; cur itself if nothing else is live
	function automatic logic [2:0] pick(input logic [2:0] cur, input logic [N_SLOT-1:0] live);
		logic [2:0] s;
		logic [2:0] res;
		logic found;
		res = cur;
		found = 1'b0;
		for (int k = 1; k <= N_SLOT; k++) begin
			s = 3'((int'(cur) + k) % N_SLOT);
			if (!found && live[s]) begin
				res = s;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	// Record bytes arrive one per strobe; first marks byte 0, extras beyond 14 dropped
	assign next_idx = link.prm_first ? IDX_W'(BYTE_BASE) : wr_idx;

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			wr_idx <= '0;
		end else if (apply) begin
			wr_idx <= '0;
		end else if (link.prm_valid && (next_idx < IDX_W'(REC_BYTES))) begin
			wr_idx <= next_idx + 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			shadow <= '0;
		end else if (link.prm_valid && (next_idx < IDX_W'(REC_BYTES))) begin
			shadow[next_idx] <= link.prm_byte;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			run_q <= 1'b0;
		end else begin
			run_q <= link.run;
		end
	end

	assign apply = link.run && !run_q;

	// Active setup changes only at the stop-to-run edge; no record keeps the old setup
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			act_base <= DEF_BASE;
			act_integ <= DEF_INTEG;
			act_in <= {N_IN{DEF_IN_CFG}};
			act_out <= {N_OUT{DEF_OUT_CFG}};
			rec_bad <= 1'b0;
		end else if (apply && (wr_idx != '0)) begin
			act_base <= shadow[BYTE_BASE];
			act_integ <= shadow[BYTE_INTEG];
			act_in <= shadow[BYTE_IN0+N_IN-1:BYTE_IN0];
			act_out <= shadow[BYTE_OUT0+N_OUT-1:BYTE_OUT0];
			rec_bad <= (wr_idx != IDX_W'(REC_BYTES));
		end
	end

	assign data_base_o = act_base;

	for (genvar i = 0; i < N_IN; i++) begin : g_in
		logic [3:0] ty;
		logic [3:0] rg;
		logic [1:0] it;
		in_mode_t mode;
		logic err;
		logic signed [WORD_W-1:0] word;

		assign ty = act_in[i][7:4];
		assign rg = act_in[i][3:0];
		assign it = act_integ[2*i+1:2*i];

		always_comb begin
			mode = MODE_OFF;
			err = 1'b0;
			if (ty == TYPE_OFF && rg == RNG_OFF) begin
				mode = MODE_OFF;
			end else if (ty == TYPE_VOLT && rg == RNG_10V && i >= VOLT_CH_MIN) begin
				mode = MODE_VOLT;
			end else if (ty == TYPE_RES && rg == RNG_10K) begin
				mode = MODE_RES;
			end else if (ty == TYPE_RTD && rg == RNG_PT) begin
				mode = MODE_RTD;
			end else begin
				err = 1'b1;
			end
			if (mode != MODE_OFF && it != INTEG_16MS && it != INTEG_20MS) begin
				err = 1'b1;
			end
			if (rec_bad) begin
				err = 1'b1;
			end
		end

		assign in_err[i] = err;
		assign in_live[i] = !err && (mode != MODE_OFF);

		in_scaler u_scaler (
			.mode_i(mode),
			.fahrenheit_i(fahrenheit_i),
			.raw_i(raw_i[i]),
			.word_o(word)
		);

		always_ff @(posedge mclk_i) begin
			if (!rst_b_i) begin
				in_word_q[i] <= W_PRM_ERROR;
			end else if (!in_live[i]) begin
				in_word_q[i] <= W_PRM_ERROR;
			end else if (slot_end && slot == 3'(i)) begin
				in_word_q[i] <= word;
			end
		end
	end

	assign link.in_word = in_word_q;

	for (genvar j = 0; j < N_OUT; j++) begin : g_out
		logic [3:0] ty;
		logic [3:0] rg;
		logic signed [WORD_W-1:0] w;

		assign ty = act_out[j][7:4];
		assign rg = act_out[j][3:0];
		assign w = link.out_word[j];
		// Anything but a proper voltage setup leaves the output at 0 V
		assign out_live[j] = (ty == TYPE_VOLT) && (rg == RNG_10V);

		always_ff @(posedge mclk_i) begin
			if (!rst_b_i) begin
				dac_o[j] <= DAC_ZERO;
			end else if (!out_live[j]) begin
				dac_o[j] <= DAC_ZERO;
			end else if (slot_end && slot == 3'(N_IN + j)) begin
				if (w[SIGN_BIT] || (w > OUT_MAX)) begin
					dac_o[j] <= DAC_ZERO;
				end else begin
					dac_o[j] <= w[DAC_MSB:DAC_LSB];
				end
			end
		end
	end

	// Deactivated or faulty channels get no slot, so the scan gets shorter
	assign slot_live = {out_live, in_live};
	assign next_slot = pick(slot, slot_live);
	assign slot_len = (slot < 3'(N_IN)) ?
		((act_integ[{slot[1:0], 1'b0} +: 2] == INTEG_16MS) ? CNT_W'(INT16_CYC - 1) : CNT_W'(INT20_CYC - 1)) :
		CNT_W'(OUT_CYC - 1);
	assign slot_end = (state == SC_CONV) && (cnt == slot_len) && slot_live[slot];

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state <= SC_PICK;
			slot <= 3'(N_SLOT - 1);
			cnt <= '0;
		end else if (apply) begin
			state <= SC_PICK;
			cnt <= '0;
		end else begin
			case (state)
				SC_PICK: begin
					if (|slot_live) begin
						slot <= next_slot;
						cnt <= '0;
						state <= SC_CONV;
					end
				end
				SC_CONV: begin
					if (!slot_live[slot] || slot_end) begin
						state <= SC_PICK;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				default: begin
					state <= SC_PICK;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			slot_done_o <= '0;
			prm_error_o <= '0;
		end else begin
			slot_done_o <= slot_end ? (N_SLOT'(1) << slot) : '0;
			prm_error_o <= in_err;
		end
	end
endmodule

// ### aio_ctl.sv
// Controller end: holds the parameter record, sends it at run, moves words
`timescale 1ns/1ns
module aio_ctl (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic cfg_we_i,
	input wire logic [aio_pkg::IDX_W-1:0] cfg_addr_i,
	input wire logic [7:0] cfg_data_i,
	input wire logic [aio_pkg::N_OUT-1:0][aio_pkg::WORD_W-1:0] out_word_i,
	output logic [aio_pkg::N_IN-1:0][aio_pkg::WORD_W-1:0] in_word_o,
	output logic busy_o,
	aio_link.ctl link
);
	import aio_pkg::*;

	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_SEND = 3'b010,
		ST_RUN = 3'b100
	} ctl_state_t;

	logic [REC_BYTES-1:0][7:0] rec;
	logic [IDX_W-1:0] idx;
	ctl_state_t state;
	logic [7:0] prm_byte_q;
	logic prm_valid_q;
	logic prm_first_q;
	logic run_link_q;
	logic [N_OUT-1:0][WORD_W-1:0] out_q;
	logic [N_IN-1:0][WORD_W-1:0] in_q;

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			rec <= {{(REC_BYTES - BYTE_OUT0 - N_OUT){DEF_SPARE}}, {N_OUT{DEF_OUT_CFG}}, {N_IN{DEF_IN_CFG}},
				DEF_INTEG, DEF_BASE};
		end else if (cfg_we_i && (cfg_addr_i < IDX_W'(REC_BYTES))) begin
			rec[cfg_addr_i] <= cfg_data_i;
		end
	end

	// Whole record goes out on entry to run, then the link run level rises
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state <= ST_STOP;
			idx <= '0;
		end else begin
			case (state)
				ST_STOP: begin
					if (run_i) begin
						state <= ST_SEND;
						idx <= '0;
					end
				end
				ST_SEND: begin
					if (!run_i) begin
						state <= ST_STOP;
					end else if (idx == IDX_W'(REC_BYTES - 1)) begin
						state <= ST_RUN;
					end else begin
						idx <= idx + 1'b1;
					end
				end
				ST_RUN: begin
					if (!run_i) begin
						state <= ST_STOP;
					end
				end
				default: begin
					state <= ST_STOP;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			prm_byte_q <= '0;
			prm_valid_q <= 1'b0;
			prm_first_q <= 1'b0;
			run_link_q <= 1'b0;
		end else begin
			prm_byte_q <= rec[idx];
			prm_valid_q <= (state == ST_SEND) && run_i;
			prm_first_q <= (state == ST_SEND) && run_i && (idx == '0);
			run_link_q <= (state == ST_RUN) && run_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			out_q <= '0;
			in_q <= '0;
		end else begin
			out_q <= out_word_i;
			in_q <= link.in_word;
		end
	end

	assign link.prm_byte = prm_byte_q;
	assign link.prm_valid = prm_valid_q;
	assign link.prm_first = prm_first_q;
	assign link.run = run_link_q;
	assign link.out_word = out_q;
	assign in_word_o = in_q;
	assign busy_o = (state == ST_SEND);
endmodule

// ### aio_checker.sv
// Link assertions between the controller and device ends
`timescale 1ns/1ns
module aio_checker (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic prm_valid_i,
	input wire logic prm_first_i,
	input wire logic [aio_pkg::N_IN-1:0][aio_pkg::WORD_W-1:0] in_word_i
);
	import aio_pkg::*;
	logic [N_IN-1:0] coded;
	// Every input word is at or above the lowest scaled value TF_UNDER_MIN, or is the underflow code
	always_comb begin
		for (int i = 0; i < N_IN; i++) begin
			coded[i] = ($signed(in_word_i[i]) >= TF_UNDER_MIN) || (in_word_i[i] == W_UNDERFLOW);
		end
	end
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	property p_first_valid;
		prm_first_i |-> prm_valid_i;
	endproperty
	a_first_valid: assert property (p_first_valid) else $error("marker without strobe");
	property p_valid_first;
		$rose(prm_valid_i) |-> prm_first_i;
	endproperty
	a_valid_first: assert property (p_valid_first) else $error("record not started at byte 0");
	property p_burst;
		prm_first_i ##1 prm_valid_i [*8] ##1 prm_valid_i [*5] |=> !prm_valid_i && run_i;
	endproperty
	a_burst: assert property (p_burst) else $error("record not 14 bytes then run");
	property p_no_run_send;
		prm_valid_i |-> !run_i;
	endproperty
	a_no_run_send: assert property (p_no_run_send) else $error("byte sent while running");
	property p_run_rise;
		$rose(run_i) |-> $past(prm_first_i, 14);
	endproperty
	a_run_rise: assert property (p_run_rise) else $error("run without full record");
	property p_send_from_stop;
		prm_first_i |-> !$past(run_i);
	endproperty
	a_send_from_stop: assert property (p_send_from_stop) else $error("send not from stop");
	property p_coded;
		&coded;
	endproperty
	a_coded: assert property (p_coded) else $error("input word outside coding");
	property p_reset_word;
		$rose(rst_b_i) |-> in_word_i == {N_IN{W_PRM_ERROR}};
	endproperty
	a_reset_word: assert property (p_reset_word) else $error("input words not error after reset");
endmodule

// ### tb.sv
// Self-checking bench for both ends of the analog I/O link
`timescale 1ns/1ns
module tb;
	import aio_pkg::*;
	typedef struct {int ch; logic [7:0] cfg; logic fa; int raw; logic [15:0] ow; logic [15:0] iw; logic [11:0] dac;} row_t;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic run_i = 1'b0;
	logic cfg_we_i = 1'b0;
	logic [IDX_W-1:0] cfg_addr_i = '0;
	logic [7:0] cfg_data_i = '0;
	logic [N_OUT-1:0][WORD_W-1:0] out_word_i = '0;
	logic [N_IN-1:0][WORD_W-1:0] in_word_o;
	logic busy_o;
	logic fahrenheit_i = 1'b0;
	logic [N_IN-1:0][RAW_W-1:0] raw_i = '0;
	logic [N_OUT-1:0][DAC_W-1:0] dac_o;
	logic [7:0] data_base_o;
	logic [N_IN-1:0] prm_error_o;
	logic [N_IN+N_OUT-1:0] slot_done_o;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	// Channel, setup byte, unit, raw, output word, expected input word, expected DAC code
	row_t rows[14] = '{
		'{0, 8'h80, 1'b0, 15500, 16'h6c00, 16'h3c8c, 12'hd80},
		'{0, 8'h80, 1'b0, 15501, 16'h7eff, 16'h7fff, 12'hfdf},
		'{1, 8'h80, 1'b0, -14500, 16'h7f00, 16'hc75c, 12'h000},
		'{1, 8'h80, 1'b0, -14501, 16'hffff, 16'h8000, 12'h000},
		'{2, 8'h80, 1'b1, 10000, 16'he500, 16'h52d0, 12'h000},
		'{3, 8'h18, 1'b0, 10000, 16'h0007, 16'h6c00, 12'h000},
		'{3, 8'h18, 1'b0, 11759, 16'h000f, 16'h7eff, 12'h001},
		'{3, 8'h18, 1'b0, 11760, 16'h5100, 16'h7fff, 12'ha20},
		'{2, 8'h49, 1'b0, 7500, 16'h0000, 16'h5100, 12'h000},
		'{2, 8'h49, 1'b0, -1800, 16'h0008, 16'h8000, 12'h001},
		'{0, 8'h18, 1'b0, 100, 16'h3fff, 16'h7fff, 12'h7ff},
		'{0, 8'h80, 1'b0, 50, 16'h0064, 16'h0032, 12'h00c},
		'{0, 8'h55, 1'b0, 50, 16'h8000, 16'h7fff, 12'h000},
		'{1, 8'h00, 1'b0, 50, 16'h7eff, 16'h7fff, 12'hfdf}
	};
	aio_link lnk();
	aio_ctl i_aio_ctl (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .run_i(run_i), .cfg_we_i(cfg_we_i),
		.cfg_addr_i(cfg_addr_i), .cfg_data_i(cfg_data_i), .out_word_i(out_word_i),
		.in_word_o(in_word_o), .busy_o(busy_o), .link(lnk));
	aio_device #(.INT16_CYC(4), .INT20_CYC(6), .OUT_CYC(3)) i_aio_device (.mclk_i(mclk_i),
		.rst_b_i(rst_b_i), .link(lnk), .fahrenheit_i(fahrenheit_i), .raw_i(raw_i), .dac_o(dac_o),
		.data_base_o(data_base_o), .prm_error_o(prm_error_o), .slot_done_o(slot_done_o));
	aio_checker i_aio_checker (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .run_i(lnk.run),
		.prm_valid_i(lnk.prm_valid), .prm_first_i(lnk.prm_first), .in_word_i(lnk.in_word));
	always #4 mclk_i = ~mclk_i;
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input int a, input logic [7:0] d);
		@(posedge mclk_i);
		cfg_we_i <= 1'b1;
		cfg_addr_i <= IDX_W'(a);
		cfg_data_i <= d;
	endtask
	// Stop, restart so the record is sent, then wait for slot k after the apply
	task automatic go(input int k);
		int n;
		logic busy_seen;
		n = 0;
		busy_seen = 1'b0;
		@(posedge mclk_i);
		cfg_we_i <= 1'b0;
		run_i <= 1'b0;
		@(posedge mclk_i);
		run_i <= 1'b1;
		do begin
			@(negedge mclk_i);
			n++;
			if (busy_o === 1'b1) begin
				busy_seen = 1'b1;
			end
		end while (lnk.run !== 1'b1 && n < 100);
		chk(16'(busy_seen), 16'h0001);
		chk(16'(busy_o), 16'h0000);
		@(negedge mclk_i);
		// Two pulses of slot k: one whole scan round has run under the new setup
		repeat (2) begin
			do begin
				@(negedge mclk_i);
				n++;
			end while (slot_done_o[k] !== 1'b1 && n < 400);
		end
		@(negedge mclk_i);
		if (n >= 400) begin
			num_errors++;
			$display("CHECK FAILED at %0t: no slot end", $time);
		end
	endtask
	task automatic run_case(input row_t r);
		wr(BYTE_IN0 + r.ch, r.cfg);
		fahrenheit_i <= r.fa;
		raw_i[r.ch] <= RAW_W'(r.raw);
		out_word_i[0] <= r.ow;
		go(4);
		chk(in_word_o[r.ch], r.iw);
		chk(16'(dac_o[0]), 16'(r.dac));
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		out_word_i[1] <= 16'h6c00;
		foreach (rows[i]) begin
			run_case(rows[i]);
		end
		// Start address and a bad integration code on every input
		wr(BYTE_BASE, 8'h5a);
		wr(BYTE_INTEG, 8'h00);
		go(4);
		chk(16'(data_base_o), 16'h005a);
		chk(in_word_o[2], 16'h7fff);
		chk(in_word_o[3], 16'h7fff);
		chk(16'(prm_error_o), 16'h000d);
		wr(BYTE_INTEG, 8'haa);
		wr(BYTE_OUT0 + 1, 8'h00);
		go(4);
		chk(in_word_o[2], 16'h8000);
		chk(16'(dac_o[1]), 16'h0000);
		// Reset in mid-run falls back to the power-on setup
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		raw_i[1] <= 32'd1234;
		repeat (10) @(posedge mclk_i);
		@(negedge mclk_i);
		chk(lnk.in_word[0], 16'h7fff);
		chk(16'(dac_o[0]), 16'h0000);
		chk(in_word_o[0], 16'h0000);
		chk(16'(busy_o), 16'h0000);
		@(posedge mclk_i);
		rst_b_i <= 1'b1;
		go(5);
		chk(in_word_o[1], 16'h04d2);
		chk(16'(dac_o[1]), 16'h0d80);
		chk(16'(data_base_o), 16'h0000);
		tally_and_finish();
	end
endmodule
